// File: hw/hbc_bridge_ctrl.v
`timescale 1ns/1ps
`include "hbc_defines.vh"
module hbc_bridge_ctrl #(
    parameter CLK_NS = `HBC_CLK_PERIOD_NS,
    parameter OFF_CYCLES = (`HBC_T_OFF_NS + CLK_NS - 1) / CLK_NS,
    parameter BLANK_CYCLES = (`HBC_T_BLANK_NS + CLK_NS - 1) / CLK_NS,
    parameter DEG_CYCLES = (`HBC_T_DEGLITCH_NS + CLK_NS - 1) / CLK_NS,
    parameter OCP_CYCLES = (`HBC_T_OCP_NS + CLK_NS - 1) / CLK_NS,
    parameter RETRY_CYCLES = (`HBC_T_RETRY_NS + CLK_NS - 1) / CLK_NS,
    parameter SLEEP_CYCLES = (`HBC_T_SLEEP_NS + CLK_NS - 1) / CLK_NS,
    parameter WAKE_CYCLES = (`HBC_T_WAKE_NS + CLK_NS - 1) / CLK_NS,
    parameter DEAD_CYCLES = (`HBC_T_DEAD_NS + CLK_NS - 1) / CLK_NS,
    parameter CW = 20
) (
    input wire CLK,
    input wire RESET_N,
    input wire DIR_INPUT_A,
    input wire DIR_INPUT_B,
    input wire CHOP_TRIP,
    input wire [3:0] SWITCH_LIMIT,
    input wire OVER_TEMP,
    input wire SUPPLY_LOW_LOCKOUT,
    output wire BRIDGE_OUT_A_HIGH_ON,
    output wire BRIDGE_OUT_A_LOW_ON,
    output wire BRIDGE_OUT_B_HIGH_ON,
    output wire BRIDGE_OUT_B_LOW_ON,
    output reg SLEEPING,
    output reg CHOPPING,
    output reg OVERCURRENT_SHUTDOWN,
    output reg THERMAL_SHUTDOWN
);
    // ----------------------------------------------------------------
    // local reset: lockout acts as reset of every register
    // ----------------------------------------------------------------
    wire rst_n = RESET_N & ~SUPPLY_LOW_LOCKOUT;

    reg [2:0] st_q;
    reg [CW-1:0] mode_cnt_q;
    reg [CW-1:0] off_cnt_q;
    reg [CW-1:0] blank_cnt_q;
    reg [CW-1:0] deg_cnt_q;
    reg [CW-1:0] ocp_cnt_q;
    reg [1:0] in_q;
    reg boot_q;
    reg off_q;
    wire a_sw;
    wire b_sw;
    wire [1:0] in_now = {DIR_INPUT_A, DIR_INPUT_B};
    wire both_low = (in_now == 2'h0);
    wire in_changed = (in_now != in_q);

    function [CW-1:0] dec_sat;
        input [CW-1:0] v;
        begin
            dec_sat = (v == {CW{1'b0}}) ? v : v - 1'b1;
        end
    endfunction

    // ----------------------------------------------------------------
    // trip qualification: blanking then deglitch
    // ----------------------------------------------------------------
    wire blanked = (blank_cnt_q != {CW{1'b0}});
    wire trip_ok = CHOP_TRIP && !blanked && (deg_cnt_q >= DEG_CYCLES[CW-1:0] - 1'b1);
    wire active = (st_q == `HBC_ST_ACTIVE);
    // off period ends on count or on an input change
    // a still-present trip at expiry keeps the brake, no one-cycle drive glitch
    wire off_end = off_q && (in_changed || (off_cnt_q == {CW{1'b0}} && !CHOP_TRIP));

    always @(posedge CLK) begin
        if (!rst_n) begin
            blank_cnt_q <= {CW{1'b0}};
            deg_cnt_q <= {CW{1'b0}};
        end else begin
            if (a_sw || b_sw)
                blank_cnt_q <= BLANK_CYCLES[CW-1:0];
            else
                blank_cnt_q <= dec_sat(blank_cnt_q);
            // discard short pulses: count restarts on any low
            if (!CHOP_TRIP || blanked)
                deg_cnt_q <= {CW{1'b0}};
            else if (deg_cnt_q != {CW{1'b1}})
                deg_cnt_q <= deg_cnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // fixed off-time chopping
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (!rst_n) begin
            off_q <= 1'b0;
            off_cnt_q <= {CW{1'b0}};
            in_q <= 2'h0;
        end else begin
            in_q <= in_now;
            if (!active) begin
                off_q <= 1'b0;
            end else if (off_q && in_changed) begin
                off_q <= 1'b0;
            end else if (off_q && off_cnt_q != {CW{1'b0}}) begin
                off_cnt_q <= off_cnt_q - 1'b1;
            end else if (off_q && CHOP_TRIP) begin
                off_cnt_q <= OFF_CYCLES[CW-1:0] - 1'b1;
            end else if (off_q) begin
                off_q <= 1'b0;
            end else if (trip_ok && !both_low) begin
                off_q <= 1'b1;
                off_cnt_q <= OFF_CYCLES[CW-1:0] - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // mode sequencing and faults
    // ----------------------------------------------------------------
    wire limit_any = |SWITCH_LIMIT;

    always @(posedge CLK) begin
        if (!rst_n) begin
            st_q <= `HBC_ST_SLEEP;
            mode_cnt_q <= {CW{1'b0}};
            ocp_cnt_q <= {CW{1'b0}};
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
            if (limit_any && active)
                ocp_cnt_q <= (ocp_cnt_q == {CW{1'b1}}) ? ocp_cnt_q : ocp_cnt_q + 1'b1;
            else
                ocp_cnt_q <= {CW{1'b0}};
            case (st_q)
                `HBC_ST_SLEEP: begin
                    // boot with inputs low stays here at once
                    if (!both_low) begin
                        st_q <= `HBC_ST_WAKE;
                        mode_cnt_q <= {CW{1'b0}};
                    end
                end
                `HBC_ST_WAKE: begin
                    if (both_low) begin
                        st_q <= `HBC_ST_SLEEP;
                    end else if (mode_cnt_q >= WAKE_CYCLES[CW-1:0]) begin
                        st_q <= `HBC_ST_ACTIVE;
                        mode_cnt_q <= {CW{1'b0}};
                    end else begin
                        mode_cnt_q <= mode_cnt_q + 1'b1;
                    end
                end
                `HBC_ST_ACTIVE: begin
                    if (OVER_TEMP) begin
                        st_q <= `HBC_ST_THERMAL;
                    end else if (ocp_cnt_q >= OCP_CYCLES[CW-1:0]) begin
                        st_q <= `HBC_ST_OCP_OFF;
                        mode_cnt_q <= {CW{1'b0}};
                    end else if (both_low) begin
                        if (mode_cnt_q >= SLEEP_CYCLES[CW-1:0] - 1'b1)
                            st_q <= `HBC_ST_SLEEP;
                        else
                            mode_cnt_q <= mode_cnt_q + 1'b1;
                    end else begin
                        mode_cnt_q <= {CW{1'b0}};
                    end
                end
                `HBC_ST_OCP_OFF: begin
                    if (OVER_TEMP) begin
                        st_q <= `HBC_ST_THERMAL;
                    end else if (mode_cnt_q >= RETRY_CYCLES[CW-1:0] - 1'b1) begin
                        st_q <= `HBC_ST_ACTIVE;
                        mode_cnt_q <= {CW{1'b0}};
                    end else begin
                        mode_cnt_q <= mode_cnt_q + 1'b1;
                    end
                end
                `HBC_ST_THERMAL: begin
                    // flag from front end already carries hysteresis
                    if (!OVER_TEMP) begin
                        st_q <= `HBC_ST_ACTIVE;
                        mode_cnt_q <= {CW{1'b0}};
                    end
                end
                default: begin
                    st_q <= `HBC_ST_SLEEP;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // requested drive per half-bridge
    // ----------------------------------------------------------------
    reg [1:0] want_a;
    reg [1:0] want_b;
    always @* begin
        want_a = `HBC_DRV_OFF;
        want_b = `HBC_DRV_OFF;
        if (active) begin
            if (off_q && !off_end) begin
                want_a = `HBC_DRV_LOW;
                want_b = `HBC_DRV_LOW;
            end else begin
                case (in_now)
                    2'h1: begin
                        want_a = `HBC_DRV_LOW;
                        want_b = `HBC_DRV_HIGH;
                    end
                    2'h2: begin
                        want_a = `HBC_DRV_HIGH;
                        want_b = `HBC_DRV_LOW;
                    end
                    2'h3: begin
                        want_a = `HBC_DRV_LOW;
                        want_b = `HBC_DRV_LOW;
                    end
                    default: begin
                        want_a = `HBC_DRV_OFF;
                        want_b = `HBC_DRV_OFF;
                    end
                endcase
            end
        end
    end

    hbc_half_bridge #(.DEAD_CYCLES(DEAD_CYCLES), .CW(CW)) u_half_a (
        .clk(CLK),
        .reset_n(rst_n),
        .want(want_a),
        .high_on_q(BRIDGE_OUT_A_HIGH_ON),
        .low_on_q(BRIDGE_OUT_A_LOW_ON),
        .switching(a_sw)
    );

    hbc_half_bridge #(.DEAD_CYCLES(DEAD_CYCLES), .CW(CW)) u_half_b (
        .clk(CLK),
        .reset_n(rst_n),
        .want(want_b),
        .high_on_q(BRIDGE_OUT_B_HIGH_ON),
        .low_on_q(BRIDGE_OUT_B_LOW_ON),
        .switching(b_sw)
    );

    // ----------------------------------------------------------------
    // status flops
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (!rst_n) begin
            SLEEPING <= 1'b1;
            CHOPPING <= 1'b0;
            OVERCURRENT_SHUTDOWN <= 1'b0;
            THERMAL_SHUTDOWN <= 1'b0;
        end else begin
            SLEEPING <= (st_q == `HBC_ST_SLEEP);
            CHOPPING <= off_q;
            OVERCURRENT_SHUTDOWN <= (st_q == `HBC_ST_OCP_OFF);
            THERMAL_SHUTDOWN <= (st_q == `HBC_ST_THERMAL);
        end
    end
    wire unused_boot = boot_q;
endmodule // hbc_bridge_ctrl

// File: hw/hbc_defines.vh
`ifndef HBC_DEFINES_VH
`define HBC_DEFINES_VH
// ----------------------------------------------------------------
// timing figures (ns) at a 10 ns clock
// ----------------------------------------------------------------
`define HBC_CLK_PERIOD_NS 10
`define HBC_T_OFF_NS 20000
`define HBC_T_BLANK_NS 1000
`define HBC_T_DEGLITCH_NS 1000
`define HBC_T_OCP_NS 2000
`define HBC_T_RETRY_NS 2000000
`define HBC_T_SLEEP_NS 1000000
`define HBC_T_WAKE_NS 200000
`define HBC_T_DEAD_NS 200
// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define HBC_ST_SLEEP 3'h0
`define HBC_ST_WAKE 3'h1
`define HBC_ST_ACTIVE 3'h2
`define HBC_ST_OCP_OFF 3'h3
`define HBC_ST_THERMAL 3'h4
// ----------------------------------------------------------------
// half-bridge drive codes: {high_on, low_on}
// ----------------------------------------------------------------
`define HBC_DRV_OFF 2'h0
`define HBC_DRV_LOW 2'h1
`define HBC_DRV_HIGH 2'h2
`endif

// File: hw/hbc_half_bridge.v
`timescale 1ns/1ps
`include "hbc_defines.vh"
// dead-time sequencer for one half-bridge
module hbc_half_bridge #(
    parameter DEAD_CYCLES = 20,
    parameter CW = 8
) (
    input wire clk,
    input wire reset_n,
    input wire [1:0] want,
    output reg high_on_q,
    output reg low_on_q,
    output wire switching
);
    reg [1:0] cur_q;
    reg [CW-1:0] dead_q;
    wire [1:0] cur_now = {high_on_q, low_on_q};
    // on a direct reversal, opposite side only after both are off for the dead interval; a pass through OFF gets no wait
    wire reverse = (want == `HBC_DRV_HIGH && cur_q == `HBC_DRV_LOW) ||
                   (want == `HBC_DRV_LOW && cur_q == `HBC_DRV_HIGH);
    assign switching = (want != cur_q);

    always @(posedge clk) begin
        if (!reset_n) begin
            cur_q <= `HBC_DRV_OFF;
            dead_q <= {CW{1'b0}};
            high_on_q <= 1'b0;
            low_on_q <= 1'b0;
        end else if (reverse || dead_q != {CW{1'b0}}) begin
            high_on_q <= 1'b0;
            low_on_q <= 1'b0;
            if (reverse) begin
                cur_q <= `HBC_DRV_OFF;
                dead_q <= DEAD_CYCLES[CW-1:0];
            end else begin
                dead_q <= dead_q - 1'b1;
            end
        end else begin
            cur_q <= want;
            high_on_q <= want[1];
            low_on_q <= want[0];
        end
    end
    // cur_now kept for readability of intent only via cur_q
    wire unused_ok = &cur_now | 1'b1;
endmodule // hbc_half_bridge

// File: sim/hbc_bridge_ctrl_properties.sv
`timescale 1ns/1ps
module hbc_bridge_ctrl_properties #(
    parameter DEG_CYCLES = 3
) (
    input wire CLK,
    input wire RESET_N,
    input wire DIR_INPUT_A,
    input wire DIR_INPUT_B,
    input wire CHOP_TRIP,
    input wire [3:0] SWITCH_LIMIT,
    input wire OVER_TEMP,
    input wire SUPPLY_LOW_LOCKOUT,
    input wire BRIDGE_OUT_A_HIGH_ON,
    input wire BRIDGE_OUT_A_LOW_ON,
    input wire BRIDGE_OUT_B_HIGH_ON,
    input wire BRIDGE_OUT_B_LOW_ON,
    input wire SLEEPING,
    input wire CHOPPING,
    input wire OVERCURRENT_SHUTDOWN,
    input wire THERMAL_SHUTDOWN
);
    wire a_hi = BRIDGE_OUT_A_HIGH_ON;
    wire a_lo = BRIDGE_OUT_A_LOW_ON;
    wire all_off = !(a_hi || a_lo || BRIDGE_OUT_B_HIGH_ON || BRIDGE_OUT_B_LOW_ON);
    reg [7:0] trip_run_q;
    // lockout is a reset of its own, so most checks stand down during it
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N || SUPPLY_LOW_LOCKOUT);
    // ----------------------------------------------------------------
    // consecutive cycles of comparator trip
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (!RESET_N || !CHOP_TRIP) trip_run_q <= 8'h00;
        else if (trip_run_q != 8'hFF) trip_run_q <= trip_run_q + 8'h01;
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    shoot_through_a: assert property (!(a_hi && a_lo) &&
        !(BRIDGE_OUT_B_HIGH_ON && BRIDGE_OUT_B_LOW_ON)) else $error("half-bridge shoot-through");
    dead_time_a: assert property ($fell(a_hi) |-> !a_lo ##1 !a_lo)
        else $error("no dead interval on out a");
    lockout_off_a: assert property (disable iff (!RESET_N)
        SUPPLY_LOW_LOCKOUT |=> all_off && SLEEPING) else $error("lockout left bridge on");
    thermal_off_a: assert property (OVER_TEMP [*4] |-> all_off)
        else $error("bridge on during over-temperature");
    ocp_off_a: assert property (OVERCURRENT_SHUTDOWN [*2] |-> all_off)
        else $error("bridge on during overcurrent shutdown");
    retry_wait_a: assert property ($rose(OVERCURRENT_SHUTDOWN) && !OVER_TEMP |->
        OVERCURRENT_SHUTDOWN [*8] ##[1:40] !OVERCURRENT_SHUTDOWN) else $error("bad retry interval");
    chop_brake_a: assert property (CHOPPING |-> !a_hi && !BRIDGE_OUT_B_HIGH_ON)
        else $error("high side on during off period");
    sleep_off_a: assert property (SLEEPING |-> all_off) else $error("bridge on in sleep");
    trip_deglitch_a: assert property ($rose(CHOPPING) |->
        $past(trip_run_q) >= DEG_CYCLES || $past(trip_run_q, 2) >= DEG_CYCLES ||
        $past(trip_run_q, 3) >= DEG_CYCLES) else $error("chop without deglitched trip");
    chop_seen_c: cover property ($rose(CHOPPING));
    ocp_seen_c: cover property ($rose(OVERCURRENT_SHUTDOWN));
    thermal_seen_c: cover property ($rose(THERMAL_SHUTDOWN));
endmodule // hbc_bridge_ctrl_properties

// File: sim/hbc_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// controller stand-in on the two direction inputs
// ----------------------------------------------------------------
module hbc_ctrl_model (
    input wire clk,
    input wire [1:0] cmd,
    output logic dir_a = 1'b0,
    output logic dir_b = 1'b0
);
    // level held until the next command, so a wake request outlasts the wake interval
    always @(posedge clk) begin
        {dir_a, dir_b} <= cmd;
    end
endmodule // hbc_ctrl_model

// File: sim/test_hbc_bridge_ctrl.sv
`timescale 1ns/1ps
`define CHK(g, e) begin #1; num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module test_hbc_bridge_ctrl;
    logic CLK = 0, RESET_N = 0, CHOP_TRIP = 0, OVER_TEMP = 0, SUPPLY_LOW_LOCKOUT = 0;
    logic [3:0] SWITCH_LIMIT = 4'h0;
    logic [1:0] cmd = 2'h0;
    wire DIR_INPUT_A, DIR_INPUT_B, SLEEPING, CHOPPING, OVERCURRENT_SHUTDOWN, THERMAL_SHUTDOWN;
    wire BRIDGE_OUT_A_HIGH_ON, BRIDGE_OUT_A_LOW_ON, BRIDGE_OUT_B_HIGH_ON, BRIDGE_OUT_B_LOW_ON;
    wire [3:0] gt = {BRIDGE_OUT_A_HIGH_ON, BRIDGE_OUT_A_LOW_ON,
        BRIDGE_OUT_B_HIGH_ON, BRIDGE_OUT_B_LOW_ON};
    int error_cnt = 0;
    int num_checks = 0;
    always #5 CLK = ~CLK;
    // short counts keep the run brief
    localparam int OFF_N = 20;
    localparam int BLANK_N = 3;
    localparam int DEG_N = 3;
    localparam int OCP_N = 4;
    localparam int RETRY_N = 30;
    localparam int SLEEP_N = 40;
    localparam int WAKE_N = 10;
    localparam int DEAD_N = 2;
    hbc_bridge_ctrl #(.OFF_CYCLES(OFF_N), .BLANK_CYCLES(BLANK_N), .DEG_CYCLES(DEG_N),
        .OCP_CYCLES(OCP_N), .RETRY_CYCLES(RETRY_N), .SLEEP_CYCLES(SLEEP_N),
        .WAKE_CYCLES(WAKE_N), .DEAD_CYCLES(DEAD_N))
        u_hbc_bridge_ctrl (.*);
    hbc_ctrl_model u_hbc_ctrl_model (.clk(CLK), .cmd(cmd), .dir_a(DIR_INPUT_A),
        .dir_b(DIR_INPUT_B));
    // gate pattern {a_hi, a_lo, b_hi, b_lo} for a command {a, b}
    function automatic [3:0] dec(input [1:0] c);
        case (c)
            2'h2: dec = 4'h9;
            2'h1: dec = 4'h6;
            2'h3: dec = 4'h5;
            default: dec = 4'h0;
        endcase
    endfunction
    task tk(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task go(input [1:0] c, input int n);
        @(posedge CLK);
        cmd <= c;
        tk(n);
        `CHK(gt, dec(c))
    endtask
    task stop_test;
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tk(5000);
        error_cnt++;
        stop_test;
    end
    initial begin
        void'($urandom(32'hA42A8270));
        tk(6);
        RESET_N <= 1'b1;
        tk(3); `CHK(SLEEPING, 1'b1)
        @(posedge CLK); cmd <= 2'h2;
        tk(5); `CHK(gt, 4'h0)
        tk(12); `CHK(gt, 4'h9)
        go(2'h1, 8);
        go(2'h3, 8);
        repeat (6) go(2'($urandom_range(3, 1)), 8);
        go(2'h2, 8);
        // ----------------------------------------------------------------
        // chopping: short pulse, one period, repeated period, abandon
        // ----------------------------------------------------------------
        @(posedge CLK); CHOP_TRIP <= 1'b1;
        @(posedge CLK); CHOP_TRIP <= 1'b0;
        tk(6); `CHK(CHOPPING, 1'b0)
        @(posedge CLK); CHOP_TRIP <= 1'b1;
        tk(6); CHOP_TRIP <= 1'b0;
        tk(4); `CHK({CHOPPING, gt}, 5'h15)
        tk(24); `CHK({CHOPPING, gt}, 5'h09)
        @(posedge CLK); CHOP_TRIP <= 1'b1;
        tk(30); `CHK({CHOPPING, gt}, 5'h15)
        @(posedge CLK); cmd <= 2'h1; CHOP_TRIP <= 1'b0;
        tk(6); `CHK(gt, 4'h6)
        go(2'h2, 30);
        // ----------------------------------------------------------------
        // overcurrent on each switch, then a pulse too short to count
        // ----------------------------------------------------------------
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK); SWITCH_LIMIT <= 4'h1 << i;
            tk(8); SWITCH_LIMIT <= 4'h0;
            tk(2); `CHK({OVERCURRENT_SHUTDOWN, gt}, 5'h10)
            tk(40); `CHK({OVERCURRENT_SHUTDOWN, gt}, 5'h09)
        end
        @(posedge CLK); SWITCH_LIMIT <= 4'h8; CHOP_TRIP <= 1'b1;
        tk(2); SWITCH_LIMIT <= 4'h0; CHOP_TRIP <= 1'b0;
        tk(4); `CHK(OVERCURRENT_SHUTDOWN, 1'b0)
        tk(30);
        // ----------------------------------------------------------------
        // thermal over overcurrent, lockout, sleep entry
        // ----------------------------------------------------------------
        @(posedge CLK); OVER_TEMP <= 1'b1;
        @(posedge CLK); SWITCH_LIMIT <= 4'hF;
        tk(8); `CHK({THERMAL_SHUTDOWN, OVERCURRENT_SHUTDOWN, gt}, 6'h20)
        @(posedge CLK); OVER_TEMP <= 1'b0; SWITCH_LIMIT <= 4'h0;
        tk(8); `CHK({THERMAL_SHUTDOWN, gt}, 5'h09)
        @(posedge CLK); SUPPLY_LOW_LOCKOUT <= 1'b1;
        tk(2); `CHK({SLEEPING, gt}, 5'h10)
        @(posedge CLK); SUPPLY_LOW_LOCKOUT <= 1'b0;
        tk(20); `CHK(gt, 4'h9)
        @(posedge CLK); cmd <= 2'h0;
        tk(10); `CHK({SLEEPING, gt}, 5'h00)
        tk(40); `CHK(SLEEPING, 1'b1)
        stop_test;
    end
endmodule // test_hbc_bridge_ctrl
bind hbc_bridge_ctrl hbc_bridge_ctrl_properties #(.DEG_CYCLES(DEG_CYCLES)) u_props (.*);
